// ===== design/ssr_device.sv
// converter end of the serial readout link: conversion timing and output shifter
// Notes on behaviour
// - clock select low uses internal bit clock
// - both controls low start conversion, internal clock
// - sixteen pulses carry previous result, MSB first
// - data changes with the falling clock edge, steady across the rising
// - after sixteen pulses clock low, tag level out
// - external clock only shifts data out
// - host external clock 20-70% high, up to 10MHz
// - external shifting needs chip select low, read high
// - result readable after finish or next conversion
// - read/convert alone starts with chip select tied
// - load during enabled high clock loses data
// - host keeps read or clock low at load
// - busy rises once new result is held
// - MSB after first rise, LSB by sixteenth
// - chain bits follow LSB, one per pulse
// - chain bits keep passing until next load
// - old result readable for 12us after start
// - host does not clock from 12us to busy
// - out of range codes saturate at full scale
// - serial data output always driven
`timescale 1ns/1ps
module ssr_device #(
	parameter int CODE_W      = ssr_pkg::CODE_IN_W,
	parameter int LOAD_CYCLES = ssr_pkg::LOAD_CYC,
	parameter int CONV_CYCLES = ssr_pkg::CONV_CYC,
	parameter int HALF_CYCLES = ssr_pkg::INT_HALF_CYC
) (
	input  wire logic                      mclk_in,
	input  wire logic                      rstn_in,
	ssr_link_if.dev                        link,
	input  wire logic signed [CODE_W-1:0]  code_in,
	output logic                           conv_start_out,
	output logic                           converting_out
);
	import ssr_pkg::*;

	typedef struct packed {
		logic [SY_W-1:0]   s1;
		logic [SY_W-1:0]   s2;
		logic              clk_d;
		logic              start_d;
		logic              converting;
		logic [CNT_W-1:0]  conv_cnt;
		logic [WORD_W-1:0] sample;
		logic [WORD_W-1:0] res;
		logic [WORD_W-1:0] sr;
		logic              sdo;
		logic              busy;
		ssr_seq_t          seq;
		logic [6:0]        half_cnt;
		logic [4:0]        pulses;
		logic              tag_cap;
		logic              sbc;
		logic              start_p;
	} ssr_dev_st_t;

	ssr_dev_st_t st;
	ssr_dev_st_t next_st;
	logic        rdc;
	logic        csn;
	logic        ext;
	logic        xclk;
	logic        tag;
	logic        start_lvl;
	logic        start;
	logic        rise;
	logic        read_en;

	// clamp the wide conversion code into the 16-bit result
	function automatic logic [WORD_W-1:0] saturate(input logic signed [CODE_W-1:0] x);
		logic signed [CODE_W-1:0] hi;
		logic signed [CODE_W-1:0] lo;
		hi = CODE_W'(WORD_MAX);
		lo = CODE_W'(WORD_MIN);
		if (x > hi) begin
			saturate = WORD_W'(WORD_MAX);
		end else if (x < lo) begin
			saturate = WORD_W'(WORD_MIN);
		end else begin
			saturate = x[WORD_W-1:0];
		end
	endfunction

	assign link.serial_result_out = st.sdo;
	assign link.busy              = st.busy;
	assign link.sbc_dev_out       = st.sbc;
	assign link.sbc_dev_oe        = !st.s2[SY_SEL];
	assign conv_start_out         = st.start_p;
	assign converting_out         = st.converting;

	always_comb begin
		next_st = st;
		next_st.s1 = {link.chain_in, link.serial_bit_clock, link.clock_source_select,
			link.cs_n, link.rd_conv};
		next_st.s2 = st.s1;
		// logic reads only s2; s1 may still be settling
		rdc  = st.s2[SY_RDC];
		csn  = st.s2[SY_CSN];
		ext  = st.s2[SY_SEL];
		xclk = st.s2[SY_CLK];
		tag  = st.s2[SY_TAG];

		// a start needs both low; chip select may simply stay low
		start_lvl = !rdc && !csn;
		start     = start_lvl && !st.start_d;
		next_st.start_d = start_lvl;
		next_st.clk_d   = xclk;
		rise    = xclk && !st.clk_d;
		read_en = !csn && rdc;
		next_st.start_p = 1'b0;

		// external clock only moves the shifter, never the conversion
		if (ext && read_en && rise) begin
			next_st.sdo = st.sr[WORD_W-1];
			next_st.sr  = {st.sr[WORD_W-2:0], tag};
		end

		// internal bit clock sequencer, one bit per pulse
		if (ext) begin
			next_st.seq = SSR_SQ_IDLE;
			next_st.sbc = 1'b0;
		end else begin
			case (st.seq)
				SSR_SQ_LOW: begin
					next_st.half_cnt = st.half_cnt + 1'b1;
					if (st.half_cnt == 7'(HALF_CYCLES - 1)) begin
						next_st.sbc      = 1'b1;
						next_st.seq      = SSR_SQ_HIGH;
						next_st.half_cnt = '0;
						if (st.pulses == '0) begin
							next_st.tag_cap = tag;
						end
					end
				end
				SSR_SQ_HIGH: begin
					next_st.half_cnt = st.half_cnt + 1'b1;
					if (st.half_cnt == 7'(HALF_CYCLES - 1)) begin
						next_st.sbc      = 1'b0;
						next_st.half_cnt = '0;
						next_st.pulses   = st.pulses + 1'b1;
						next_st.sr       = {st.sr[WORD_W-2:0], 1'b0};
						// bit changes together with the falling edge, steady across the rising one
						if (st.pulses == 5'(WORD_W - 1)) begin
							next_st.seq = SSR_SQ_IDLE;
							next_st.sdo = st.tag_cap;
						end else begin
							next_st.seq = SSR_SQ_LOW;
							next_st.sdo = st.sr[WORD_W-2];
						end
					end
				end
				default: begin
					next_st.seq = SSR_SQ_IDLE;
					next_st.sbc = 1'b0;
				end
			endcase
		end

		// conversion timing; starts are ignored while one is running
		if (start && !st.converting) begin
			next_st.converting = 1'b1;
			next_st.conv_cnt   = '0;
			next_st.busy       = 1'b0;
			next_st.start_p    = 1'b1;
			next_st.sample     = saturate(code_in);
			if (!ext) begin
				next_st.sr       = st.res;
				next_st.sdo      = st.res[WORD_W-1];
				next_st.seq      = SSR_SQ_LOW;
				next_st.half_cnt = '0;
				next_st.pulses   = '0;
				next_st.sbc      = 1'b0;
			end
		end else if (st.converting) begin
			next_st.conv_cnt = st.conv_cnt + 1'b1;
			// old word stays in the shifter until here
			if (st.conv_cnt == CNT_W'(LOAD_CYCLES - 1)) begin
				next_st.res = st.sample;
				// an enabled high clock here would split the word, so keep the old one
				if (ext && !(read_en && xclk)) begin
					next_st.sr = st.sample;
				end
			end
			if (st.conv_cnt == CNT_W'(CONV_CYCLES - 1)) begin
				next_st.converting = 1'b0;
				next_st.busy       = 1'b1;
			end
		end
		// with no edge and no load nothing above touches sdo
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			st          <= '0;
			st.busy     <= BUSY_RST;
			st.s1       <= SY_W'(3);
			st.s2       <= SY_W'(3);
			st.start_d  <= 1'b0;
			st.seq      <= SSR_SQ_IDLE;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ===== design/ssr_pkg.sv
// shared constants for the converter serial readout link
package ssr_pkg;

	localparam int CLK_MHZ      = 100;
	localparam int CLK_HZ       = CLK_MHZ * 1000000;
	localparam int WORD_W       = 16;
	localparam int WORD_MAX     = 32767;
	localparam int WORD_MIN     = -32768;
	localparam int CODE_IN_W    = 18;

	// internal bit clock, about 900 kHz
	localparam int INT_CLK_HZ   = 900000;
	localparam int INT_HALF_CYC = CLK_HZ / (2 * INT_CLK_HZ);

	// earliest result load after a start, and the conversion length
	localparam int LOAD_TIME_US = 12;
	localparam int LOAD_CYC     = LOAD_TIME_US * CLK_MHZ;
	localparam int CONV_TIME_US = 20;
	localparam int CONV_CYC     = CONV_TIME_US * CLK_MHZ;
	localparam int CNT_W        = 12;

	// external bit clock made by the host: limits and the rate used
	localparam int EXT_CLK_MAX_HZ = 10000000;
	localparam int EXT_DUTY_MIN   = 20;
	localparam int EXT_DUTY_MAX   = 70;
	localparam int EXT_CLK_HZ     = 6250000;
	localparam int EXT_HALF_CYC   = CLK_HZ / (2 * EXT_CLK_HZ);

	// length of the start strobe driven by the host
	localparam int START_CYC    = 4;
	localparam int HCNT_W       = 8;

	// positions in the device input synchroniser vector
	localparam int SY_RDC = 0;
	localparam int SY_CSN = 1;
	localparam int SY_SEL = 2;
	localparam int SY_CLK = 3;
	localparam int SY_TAG = 4;
	localparam int SY_W   = 5;

	// positions in the host input synchroniser vector
	localparam int HY_SBC  = 0;
	localparam int HY_SDO  = 1;
	localparam int HY_BUSY = 2;
	localparam int HY_W    = 3;

	localparam logic BUSY_RST = 1'b1;
	localparam logic CSN_RST  = 1'b1;
	localparam logic RDC_RST  = 1'b1;

	typedef enum logic [1:0] {
		SSR_SQ_IDLE = 2'b00,
		SSR_SQ_LOW  = 2'b01,
		SSR_SQ_HIGH = 2'b11
	} ssr_seq_t;

	typedef enum logic [2:0] {
		SSR_H_IDLE  = 3'b000,
		SSR_H_START = 3'b001,
		SSR_H_WBLO  = 3'b011,
		SSR_H_WBHI  = 3'b010,
		SSR_H_CLKHI = 3'b110,
		SSR_H_CLKLO = 3'b111,
		SSR_H_PUSH  = 3'b101
	} ssr_hstate_t;

endpackage

// ===== design/ssr_link_if.sv
// pin-level link between converter readout port and its host
`timescale 1ns/1ps
interface ssr_link_if;
	logic rd_conv;
	logic cs_n;
	logic clock_source_select;
	logic chain_in;
	logic sbc_dev_out;
	logic sbc_dev_oe;
	logic sbc_host_out;
	logic sbc_host_oe;
	logic serial_bit_clock;
	logic serial_result_out;
	logic busy;

	// bit clock wire: device drives in internal mode, host in external
	assign serial_bit_clock = sbc_dev_oe ? sbc_dev_out : (sbc_host_oe ? sbc_host_out : 1'b0);

	modport dev (
		input  rd_conv, cs_n, clock_source_select, chain_in, serial_bit_clock,
		output sbc_dev_out, sbc_dev_oe, serial_result_out, busy
	);
	modport host (
		input  serial_bit_clock, serial_result_out, busy,
		output rd_conv, cs_n, clock_source_select, chain_in, sbc_host_out, sbc_host_oe
	);
endinterface

// ===== design/ssr_buf.sv
// small valid/ready buffer built from flip-flops
`timescale 1ns/1ps
module ssr_buf #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             mclk_in,
	input  wire logic             rstn_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	import ssr_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wptr;
		logic [PW-1:0]               rptr;
		logic [CW-1:0]               count;
	} ssr_buf_st_t;

	ssr_buf_st_t st;
	ssr_buf_st_t next_st;
	logic        push;
	logic        pop;

	assign in_ready_out  = (st.count != CW'(DEPTH));
	assign out_valid_out = (st.count != '0);
	assign out_data_out  = st.mem[st.rptr];

	always_comb begin
		next_st = st;
		push = in_valid_in && in_ready_out;
		pop  = out_valid_out && out_ready_in;
		if (push) begin
			next_st.mem[st.wptr] = in_data_in;
			next_st.wptr = (st.wptr == PW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
		end
		if (pop) begin
			next_st.rptr = (st.rptr == PW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
		end
		if (push && !pop) begin
			next_st.count = st.count + 1'b1;
		end else if (pop && !push) begin
			next_st.count = st.count - 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ===== design/ssr_host.sv
// host end of the serial readout link: starts conversions, reads words
`timescale 1ns/1ps
module ssr_host #(
	parameter int HALF_CYCLES  = ssr_pkg::EXT_HALF_CYC,
	parameter int START_CYCLES = ssr_pkg::START_CYC,
	parameter int BUF_DEPTH    = 2
) (
	input  wire logic                       mclk_in,
	input  wire logic                       rstn_in,
	ssr_link_if.host                        link,
	input  wire logic                       ext_mode_in,
	input  wire logic                       chain_level_in,
	input  wire logic                       req_valid_in,
	output logic                            req_ready_out,
	output logic                            word_valid_out,
	input  wire logic                       word_ready_in,
	output logic [ssr_pkg::WORD_W-1:0]      word_out
);
	import ssr_pkg::*;

	typedef struct packed {
		logic [HY_W-1:0]   s1;
		logic [HY_W-1:0]   s2;
		logic              sbc_d;
		ssr_hstate_t       state;
		logic [HCNT_W-1:0] cnt;
		logic [4:0]        bits;
		logic [WORD_W-1:0] shreg;
		logic              rdc;
		logic              csn;
		logic              sel;
		logic              clk;
		logic              tag;
	} ssr_host_st_t;

	ssr_host_st_t st;
	ssr_host_st_t next_st;
	logic         buf_ready;
	logic         sbc_rise;

	assign link.rd_conv             = st.rdc;
	assign link.cs_n                = st.csn;
	assign link.clock_source_select = st.sel;
	assign link.chain_in            = st.tag;
	assign link.sbc_host_out        = st.clk;
	assign link.sbc_host_oe         = st.sel;
	assign req_ready_out            = (st.state == SSR_H_IDLE) && buf_ready;

	ssr_buf #(
		.WIDTH (WORD_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.mclk_in       (mclk_in),
		.rstn_in       (rstn_in),
		.in_valid_in   (st.state == SSR_H_PUSH),
		.in_ready_out  (buf_ready),
		.in_data_in    (st.shreg),
		.out_valid_out (word_valid_out),
		.out_ready_in  (word_ready_in),
		.out_data_out  (word_out)
	);

	always_comb begin
		next_st = st;
		next_st.s1 = {link.busy, link.serial_result_out, link.serial_bit_clock};
		next_st.s2 = st.s1;
		next_st.sbc_d = st.s2[HY_SBC];
		next_st.tag = chain_level_in;
		sbc_rise = st.s2[HY_SBC] && !st.sbc_d;
		case (st.state)
			SSR_H_IDLE: begin
				next_st.sel = ext_mode_in;
				// a full buffer holds off the next conversion
				if (req_valid_in && buf_ready) begin
					next_st.state = SSR_H_START;
					next_st.rdc   = 1'b0;
					next_st.csn   = 1'b0;
					next_st.cnt   = '0;
				end
			end
			SSR_H_START: begin
				next_st.cnt = st.cnt + 1'b1;
				if (st.cnt == HCNT_W'(START_CYCLES - 1)) begin
					next_st.rdc   = 1'b1;
					next_st.state = SSR_H_WBLO;
				end
			end
			SSR_H_WBLO: begin
				next_st.bits = '0;
				if (!st.s2[HY_BUSY]) begin
					next_st.state = SSR_H_WBHI;
				end
			end
			SSR_H_WBHI: begin
				// external clock stays low during conversion, so the load is safe; internal mode samples the device pulses here
				if (!st.sel && sbc_rise && st.bits != 5'(WORD_W)) begin
					next_st.shreg = {st.shreg[WORD_W-2:0], st.s2[HY_SDO]};
					next_st.bits  = st.bits + 1'b1;
				end
				if (st.s2[HY_BUSY]) begin
					next_st.cnt = '0;
					if (st.sel) begin
						next_st.clk   = 1'b1;
						next_st.state = SSR_H_CLKHI;
					end else begin
						next_st.state = SSR_H_PUSH;
					end
				end
			end
			SSR_H_CLKHI: begin
				next_st.cnt = st.cnt + 1'b1;
				if (st.cnt == HCNT_W'(HALF_CYCLES - 1)) begin
					next_st.clk   = 1'b0;
					next_st.cnt   = '0;
					next_st.shreg = {st.shreg[WORD_W-2:0], st.s2[HY_SDO]};
					next_st.bits  = st.bits + 1'b1;
					next_st.state = SSR_H_CLKLO;
				end
			end
			SSR_H_CLKLO: begin
				next_st.cnt = st.cnt + 1'b1;
				if (st.cnt == HCNT_W'(HALF_CYCLES - 1)) begin
					next_st.cnt = '0;
					if (st.bits == 5'(WORD_W)) begin
						next_st.state = SSR_H_PUSH;
					end else begin
						next_st.clk   = 1'b1;
						next_st.state = SSR_H_CLKHI;
					end
				end
			end
			SSR_H_PUSH: begin
				if (buf_ready) begin
					next_st.state = SSR_H_IDLE;
				end
			end
			default: begin
				next_st.state = SSR_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			st     <= '0;
			st.rdc <= RDC_RST;
			st.csn <= CSN_RST;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ===== testbench/ssr_link_asserts.sv
// checker on the link pins: conversion timing, bit clock and serial data
`timescale 1ns/1ps
module ssr_link_asserts (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic rd_conv,
	input wire logic cs_n,
	input wire logic clock_source_select,
	input wire logic serial_bit_clock,
	input wire logic serial_result_out,
	input wire logic busy
);
	logic [4:0] pulses;
	logic       sbc_q;
	logic       busy_q;

	// internal clock rises since the last conversion start
	always_ff @(posedge mclk_in) begin
		sbc_q <= serial_bit_clock;
		busy_q <= busy;
		if (!rstn_in || (busy_q && !busy))
			pulses <= 5'h00;
		else if (!sbc_q && serial_bit_clock && !clock_source_select)
			pulses <= pulses + 5'h01;
	end

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	start_cause_a: assert property (
		$fell(busy) |-> $past(!rd_conv && !cs_n, 2))
		else $error("busy fell without a start request");
	busy_length_a: assert property (
		$rose(busy) |-> $past(busy, 101) && !$past(busy, 100))
		else $error("busy low time differs from conversion length");
	pulse_count_a: assert property (
		$rose(busy) && !clock_source_select |-> pulses == 5'h10)
		else $error("internal burst did not hold sixteen pulses");
	half_period_a: assert property (
		$rose(serial_bit_clock) && !clock_source_select |->
		serial_bit_clock[*3] ##1 !serial_bit_clock)
		else $error("internal bit clock high phase wrong");
	data_steady_a: assert property (
		!clock_source_select && serial_bit_clock |-> $stable(serial_result_out))
		else $error("serial data moved while internal clock high");
	clock_parked_a: assert property (
		!clock_source_select && busy |-> !serial_bit_clock)
		else $error("internal bit clock active outside a burst");
	ext_shift_a: assert property (
		clock_source_select && busy && $changed(serial_result_out) |->
		$past(serial_bit_clock && rd_conv && !cs_n, 2))
		else $error("serial data changed without an enabled clock edge");
	no_clock_conv_a: assert property (
		clock_source_select && !busy |-> !serial_bit_clock)
		else $error("external clock toggled during a conversion");
	ext_duty_a: assert property (
		$rose(serial_bit_clock) && clock_source_select |->
		serial_bit_clock[*8] ##1 !serial_bit_clock[*8])
		else $error("external bit clock high or low phase wrong");
	ext_hold_a: assert property (
		clock_source_select && !busy |-> $stable(serial_result_out))
		else $error("serial data moved during an external mode conversion");
endmodule

// ===== testbench/sar_adc_serial_readout_tb.sv
// self-checking bench: converter and host ends joined over the link
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
	import ssr_pkg::*;
	logic                 mclk_in        = 1'b0;
	logic                 rstn_in        = 1'b0;
	logic [CODE_IN_W-1:0] code_in        = '0;
	logic                 ext_mode_in    = 1'b1;
	logic                 chain_level_in = 1'b0;
	logic                 req_valid_in   = 1'b0;
	logic                 word_ready_in  = 1'b0;
	logic                 req_ready_out;
	logic                 word_valid_out;
	logic [WORD_W-1:0]    word_out;
	logic                 conv_start;
	logic                 conv_flag;
	logic [WORD_W-1:0]    exp_q[$];
	logic [WORD_W-1:0]    prev           = '0;
	int                   fails          = 0;
	int                   n_tests        = 0;
	int                   cyc            = 0;
	int                   n_starts       = 0;
	// mode and chain level per step, bit i for step i
	logic [7:0]           modes          = 8'h93;
	logic [7:0]           chains         = 8'ha6;
	logic [CODE_IN_W-1:0] codes [8]      = '{18'h01234, 18'h1ffff, 18'h20000, 18'h3ffff,
		18'h08000, 18'h37fff, 18'h07fff, 18'h38000};

	ssr_link_if link ();

	// shortened conversion so the run stays brief
	ssr_device #(.LOAD_CYCLES(60), .CONV_CYCLES(100), .HALF_CYCLES(3)) i_ssr_device (
		.mclk_in        (mclk_in),
		.rstn_in        (rstn_in),
		.link           (link.dev),
		.code_in        (code_in),
		.conv_start_out (conv_start),
		.converting_out (conv_flag)
	);
	ssr_host i_ssr_host (
		.mclk_in        (mclk_in),
		.rstn_in        (rstn_in),
		.link           (link.host),
		.ext_mode_in    (ext_mode_in),
		.chain_level_in (chain_level_in),
		.req_valid_in   (req_valid_in),
		.req_ready_out  (req_ready_out),
		.word_valid_out (word_valid_out),
		.word_ready_in  (word_ready_in),
		.word_out       (word_out)
	);
	ssr_link_asserts i_ssr_link_asserts (
		.mclk_in             (mclk_in),
		.rstn_in             (rstn_in),
		.rd_conv             (link.rd_conv),
		.cs_n                (link.cs_n),
		.clock_source_select (link.clock_source_select),
		.serial_bit_clock    (link.serial_bit_clock),
		.serial_result_out   (link.serial_result_out),
		.busy                (link.busy)
	);

	always #5 mclk_in = ~mclk_in;

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// whole run needs about 2000 cycles
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (conv_start)
			n_starts <= n_starts + 1;
		if (cyc == 30000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [WORD_W-1:0] seen,
		input logic [WORD_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [WORD_W-1:0] sat(input logic signed [CODE_IN_W-1:0] c);
		if (c > 18'sh07fff)
			return 16'h7fff;
		if (c < 18'sh38000)
			return 16'h8000;
		return c[WORD_W-1:0];
	endfunction

	// one conversion; internal mode reads the previous result
	task automatic issue(input logic m, input logic [CODE_IN_W-1:0] c, input logic ch);
		int k;
		for (k = 0; k < 2000 && !req_ready_out; k++) @(posedge mclk_in);
		ext_mode_in <= m;
		chain_level_in <= ch;
		code_in <= c;
		// let the select change settle before the start
		repeat (8) @(posedge mclk_in);
		req_valid_in <= 1'b1;
		@(posedge mclk_in);
		req_valid_in <= 1'b0;
		exp_q.push_back(m ? sat(c) : prev);
		prev = sat(c);
		for (k = 0; k < 100 && link.busy; k++) @(posedge mclk_in);
		check("converting", {14'h0000, conv_flag, link.busy}, 16'h0002);
		for (k = 0; k < 300 && !link.busy; k++) @(posedge mclk_in);
		if (!m)
			check("tag level", {15'h0000, link.serial_result_out}, {15'h0000, ch});
	endtask

	task automatic drain();
		int k;
		@(posedge mclk_in);
		for (k = 0; k < 2000 && !word_valid_out; k++) @(posedge mclk_in);
		check("word valid", {15'h0000, word_valid_out}, 16'h0001);
		check("word", word_out, exp_q.pop_front());
		word_ready_in <= 1'b1;
		@(posedge mclk_in);
		word_ready_in <= 1'b0;
	endtask

	initial begin
		repeat (3) @(posedge mclk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		check("idle busy", {15'h0000, link.busy}, 16'h0001);
		// two words queue up while the reader stalls, then drain
		for (int i = 0; i < 8; i += 2) begin
			issue(modes[i], codes[i], chains[i]);
			issue(modes[i+1], codes[i+1], chains[i+1]);
			drain();
			drain();
		end
		check("starts", WORD_W'(n_starts), 16'h0008);
		report_and_stop();
	end
endmodule
